// file: rtl/sys_option_pkg.sv
package sys_option_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] OPT_A_INDEX = 8'h1D;
	localparam logic [7:0] OPT_B_INDEX = 8'h1F;
	localparam logic [7:0] OPT_A_ADDR  = {OPT_A_INDEX[5:0], 2'b00};
	localparam logic [7:0] OPT_B_ADDR  = {OPT_B_INDEX[5:0], 2'b00};

	localparam logic [7:0] OPT_A_RESET = 8'h00;
	localparam logic [7:0] OPT_B_RESET = 8'h00;

	// system_option_a fields
	localparam int WD_PERIOD_SELECT_BIT  = 7;
	localparam int MON_IN_STOP_BIT       = 6;
	localparam int MON_RESET_DISABLE_BIT = 5;
	localparam int MON_POWER_DISABLE_BIT = 4;
	localparam int MON_REG_DISABLE_BIT   = 3;
	localparam int SHORT_RECOVERY_BIT    = 2;
	localparam int STOP_ENABLE_BIT       = 1;
	localparam int WD_DISABLE_BIT        = 0;

	// system_option_b fields
	localparam int XTAL_IN_STOP_BIT   = 3;
	localparam int RC_IN_STOP_BIT     = 2;
	localparam int USB_REG_OFF_BIT    = 1;
	localparam int USB_RESET_ROUTE_BIT = 0;

	// timing in clock cycles; counter width in bits
	localparam int WD_SHORT_CYCLES  = 8176;
	localparam int WD_LONG_CYCLES   = 262128;
	localparam int REC_SHORT_CYCLES = 32;
	localparam int REC_LONG_CYCLES  = 4096;
	localparam int COUNT_W          = 18;

	typedef struct packed {
		logic [7:0]  paddr;
		logic        pwrite;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic watchdogEnable;
		logic watchdogResetReq;
		logic lvmPowerEnable;
		logic lvmActive;
		logic lvmResetReq;
		logic stopLegal;
		logic illegalOpcodeReq;
		logic cpuClockRun;
		logic oscRunEnable;
		logic rcClockEnable;
		logic usbRegulatorEnable;
		logic usbChipResetReq;
		logic usbIrqReq;
	} ctrl_out_t;

	localparam ctrl_out_t CTRL_RESET = 13'h0000;

	typedef enum logic [1:0] {
		REC_RUN     = 2'b00,
		REC_STOPPED = 2'b01,
		REC_WAIT    = 2'b10
	} rec_state_t;

endpackage

// file: rtl/sync_two_stage.sv
`timescale 1ns/1ps
module sync_two_stage #(
	parameter int              WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			meta <= RESET_VAL;
			q    <= RESET_VAL;
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // sync_two_stage

// file: rtl/cycle_counter.sv
`timescale 1ns/1ps
module cycle_counter #(
	parameter int WIDTH = 18
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	input  wire logic             start,
	input  wire logic             halt,
	input  wire logic [WIDTH-1:0] loadValue,
	output logic                  busy,
	output logic                  done
);
	logic [WIDTH-1:0] count;

	// done in the cycle loadValue+1 cycles after start was sampled
	assign done = busy && (count == '0);

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			busy  <= 1'b0;
			count <= '0;
		end else if (ce) begin
			if (start) begin
				busy  <= 1'b1;
				count <= loadValue;
			end else if (halt || done) begin
				busy <= 1'b0;
			end else if (busy) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // cycle_counter

// file: rtl/system_option_config_regs.sv
`timescale 1ns/1ps
module system_option_config_regs #(
	parameter int WD_LONG_CYCLES = sys_option_pkg::WD_LONG_CYCLES
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rstn,
	input  wire logic                 ce,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire sys_option_pkg::apb_req_t apbReq,
	output sys_option_pkg::apb_rsp_t  apbRsp,
	input  wire logic                 stopMode,
	input  wire logic                 stopWake,
	input  wire logic                 stopOpcode,
	input  wire logic                 watchdogKick,
	input  wire logic                 lvmTripPin,
	input  wire logic                 usbResetPin,
	input  wire logic                 resetPinN,
	output sys_option_pkg::ctrl_out_t ctrl
);
	localparam int CW = sys_option_pkg::COUNT_W;

	logic [7:0]                 optionA;
	logic [7:0]                 optionB;
	logic                       locked;
	sys_option_pkg::rec_state_t recState;
	sys_option_pkg::rec_state_t next_recState;
	sys_option_pkg::apb_rsp_t   next_apbRsp;
	sys_option_pkg::ctrl_out_t  next_ctrl;

	// pin inputs, two flops each; reset pin idles high
	logic lvmTripSync;
	logic usbResetSync;
	logic resetPinSync;

	sync_two_stage #(
		.WIDTH     (3),
		.RESET_VAL (3'h1)
	) u_pin_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.ce      (ce),
		.d       ({lvmTripPin, usbResetPin, resetPinN}),
		.q       ({lvmTripSync, usbResetSync, resetPinSync})
	);

	// option fields
	wire wdPeriodSelect  = optionA[sys_option_pkg::WD_PERIOD_SELECT_BIT];
	wire monInStop       = optionA[sys_option_pkg::MON_IN_STOP_BIT];
	wire monResetDisable = optionA[sys_option_pkg::MON_RESET_DISABLE_BIT];
	wire monPowerDisable = optionA[sys_option_pkg::MON_POWER_DISABLE_BIT];
	wire monRegDisable   = optionA[sys_option_pkg::MON_REG_DISABLE_BIT];
	wire shortRecovery   = optionA[sys_option_pkg::SHORT_RECOVERY_BIT];
	wire stopEnable      = optionA[sys_option_pkg::STOP_ENABLE_BIT];
	wire wdDisable       = optionA[sys_option_pkg::WD_DISABLE_BIT];
	wire xtalInStop      = optionB[sys_option_pkg::XTAL_IN_STOP_BIT];
	wire rcInStop        = optionB[sys_option_pkg::RC_IN_STOP_BIT];
	wire usbRegOff       = optionB[sys_option_pkg::USB_REG_OFF_BIT];
	wire usbResetRoute   = optionB[sys_option_pkg::USB_RESET_ROUTE_BIT];

	// APB decode; one wait state, completion when pready is seen high
	wire access   = psel && penable;
	wire setupAcc = access && !apbRsp.pready;
	wire finish   = access && apbRsp.pready;
	wire hitA     = apbReq.paddr == sys_option_pkg::OPT_A_ADDR;
	wire hitB     = apbReq.paddr == sys_option_pkg::OPT_B_ADDR;
	wire wrA      = finish && apbReq.pwrite && hitA;
	wire wrB      = finish && apbReq.pwrite && hitB;
	wire acceptA  = wrA && !locked;

	// reads ignore the lock
	wire [31:0] readData = hitA ? {24'h00_0000, optionA} :
		hitB ? {24'h00_0000, optionB} : 32'h0000_0000;

	assign next_apbRsp.pready  = setupAcc;
	assign next_apbRsp.pslverr = setupAcc && !(hitA || hitB);
	assign next_apbRsp.prdata  = (setupAcc && !apbReq.pwrite) ? readData : apbRsp.prdata;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			optionA <= sys_option_pkg::OPT_A_RESET;
			optionB <= sys_option_pkg::OPT_B_RESET;
			locked  <= 1'b0;
		end else if (ce) begin
			if (acceptA) begin
				optionA <= apbReq.pwdata[7:0];
				locked  <= 1'b1;
			end
			if (wrB) begin
				optionB <= apbReq.pwdata[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			apbRsp <= '0;
		end else if (ce) begin
			apbRsp <= next_apbRsp;
		end
	end

	// watchdog timer; restarts on kick and after each expiry
	wire            wdOn = !wdDisable;
	logic           wdBusy;
	logic           wdDone;
	wire            wdStart = wdOn && (watchdogKick || !wdBusy);
	wire [CW-1:0]   wdLoad  = wdPeriodSelect ?
		CW'(sys_option_pkg::WD_SHORT_CYCLES - 1) : CW'(WD_LONG_CYCLES - 1);

	cycle_counter #(
		.WIDTH (CW)
	) u_watchdog (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.ce        (ce),
		.start     (wdStart),
		.halt      (!wdOn),
		.loadValue (wdLoad),
		.busy      (wdBusy),
		.done      (wdDone)
	);

	// stop-mode recovery sequencer
	wire          inStop    = recState == sys_option_pkg::REC_STOPPED;
	wire          recStart  = inStop && stopWake;
	// a low reset pin at wake forces the long delay
	wire          useShort  = shortRecovery && resetPinSync;
	wire [CW-1:0] recLoad   = useShort ? CW'(sys_option_pkg::REC_SHORT_CYCLES - 1) :
		CW'(sys_option_pkg::REC_LONG_CYCLES - 1);
	logic         recDone;

	cycle_counter #(
		.WIDTH (CW)
	) u_recovery (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.ce        (ce),
		.start     (recStart),
		.halt      (1'b0),
		.loadValue (recLoad),
		.busy      (),
		.done      (recDone)
	);

	always_comb begin
		next_recState = recState;
		case (recState)
			sys_option_pkg::REC_RUN: begin
				if (stopMode) begin
					next_recState = sys_option_pkg::REC_STOPPED;
				end
			end
			sys_option_pkg::REC_STOPPED: begin
				if (stopWake) begin
					next_recState = sys_option_pkg::REC_WAIT;
				end
			end
			sys_option_pkg::REC_WAIT: begin
				if (recDone) begin
					next_recState = sys_option_pkg::REC_RUN;
				end
			end
			default: next_recState = sys_option_pkg::REC_RUN;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			recState <= sys_option_pkg::REC_RUN;
		end else if (ce) begin
			recState <= next_recState;
		end
	end

	// low-voltage monitor gating; power-disable overrides everything
	wire monStopOk = monInStop && (!monPowerDisable || !monRegDisable);
	wire monOn     = !monPowerDisable;

	assign next_ctrl.watchdogEnable     = wdOn;
	assign next_ctrl.watchdogResetReq   = wdOn && wdDone;
	assign next_ctrl.lvmPowerEnable     = monOn;
	assign next_ctrl.lvmActive          = monOn && (!inStop || monStopOk);
	assign next_ctrl.lvmResetReq        = monOn && lvmTripSync && !monResetDisable;
	assign next_ctrl.stopLegal          = stopEnable;
	assign next_ctrl.illegalOpcodeReq   = stopOpcode && !stopEnable;
	assign next_ctrl.cpuClockRun        = next_recState == sys_option_pkg::REC_RUN;
	assign next_ctrl.oscRunEnable       = !inStop || xtalInStop;
	assign next_ctrl.rcClockEnable      = !inStop || rcInStop;
	assign next_ctrl.usbRegulatorEnable = !usbRegOff;
	assign next_ctrl.usbChipResetReq    = usbResetSync && !usbResetRoute;
	assign next_ctrl.usbIrqReq          = usbResetSync && usbResetRoute;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctrl <= sys_option_pkg::CTRL_RESET;
		end else if (ce) begin
			ctrl <= next_ctrl;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn || !ce);

	property p_lock_once;
		locked && wrA |=> optionA == $past(optionA);
	endproperty
	a_lock_once: assert property (p_lock_once)
		else $error("locked option a changed");

	property p_b_rewrite;
		wrB |=> optionB == $past(apbReq.pwdata[7:0]) && !$past(wrA);
	endproperty
	a_b_rewrite: assert property (p_b_rewrite)
		else $error("option b write lost");

	property p_reset_clear;
		$rose(rstn) |-> optionA == 8'h00 && optionB == 8'h00 && !locked;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("options not clear");

	property p_read_any;
		setupAcc && !apbReq.pwrite && hitA |=> apbRsp.pready && apbRsp.prdata[7:0] == optionA;
	endproperty
	a_read_any: assert property (p_read_any)
		else $error("option a read wrong");

	property p_wd_period;
		wdStart && wdPeriodSelect |-> wdLoad == 18'h0_1FEF;
	endproperty
	a_wd_period: assert property (p_wd_period)
		else $error("short watchdog load wrong");

	property p_mon_stop;
		inStop && monInStop && !monPowerDisable |=> ctrl.lvmActive;
	endproperty
	a_mon_stop: assert property (p_mon_stop)
		else $error("monitor stopped in stop");

	property p_mon_reset;
		ctrl.lvmResetReq |-> $past(lvmTripSync) && !$past(monResetDisable);
	endproperty
	a_mon_reset: assert property (p_mon_reset)
		else $error("monitor reset not blocked");

	property p_mon_off;
		monPowerDisable |=> !ctrl.lvmActive && !ctrl.lvmPowerEnable && !ctrl.lvmResetReq;
	endproperty
	a_mon_off: assert property (p_mon_off)
		else $error("monitor on while disabled");

	property p_rec_short;
		recStart && useShort |-> ##32 recDone;
	endproperty
	a_rec_short: assert property (p_rec_short)
		else $error("short recovery not 32");

	property p_rec_pin;
		recStart && !resetPinSync |-> ##32 !recDone;
	endproperty
	a_rec_pin: assert property (p_rec_pin)
		else $error("pin exit used short delay");

	property p_stop_illegal;
		stopOpcode && !stopEnable |=> ctrl.illegalOpcodeReq && !ctrl.stopLegal;
	endproperty
	a_stop_illegal: assert property (p_stop_illegal)
		else $error("stop not flagged illegal");

	property p_wd_off;
		wdDisable |=> !ctrl.watchdogEnable && !ctrl.watchdogResetReq;
	endproperty
	a_wd_off: assert property (p_wd_off)
		else $error("watchdog active while off");

	property p_clk_stop;
		inStop |=> ctrl.oscRunEnable == $past(xtalInStop) && ctrl.rcClockEnable == $past(rcInStop);
	endproperty
	a_clk_stop: assert property (p_clk_stop)
		else $error("stop clock gating wrong");

	property p_usb;
		usbResetSync |=> ctrl.usbIrqReq == $past(usbResetRoute)
			&& ctrl.usbChipResetReq != $past(usbResetRoute)
			&& ctrl.usbRegulatorEnable != $past(usbRegOff);
	endproperty
	a_usb: assert property (p_usb)
		else $error("usb reset routing wrong");

endmodule // system_option_config_regs

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int WD_LONG = 200;
	logic                      ref_clk;
	logic                      rstn;
	logic                      psel;
	logic                      penable;
	sys_option_pkg::apb_req_t  apbReq;
	sys_option_pkg::apb_rsp_t  apbRsp;
	logic                      stopMode;
	logic                      stopWake;
	logic                      stopOpcode;
	logic                      lvmTripPin;
	logic                      usbResetPin;
	logic                      resetPinN;
	logic                      ce;
	logic                      watchdogKick;
	sys_option_pkg::ctrl_out_t ctrl;
	int                        n_errors;
	int                        cmp_count;
	logic [31:0]               rdv;
	logic                      err;

	system_option_config_regs #(.WD_LONG_CYCLES(WD_LONG)) dut (
		.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
		.apbReq(apbReq), .apbRsp(apbRsp), .stopMode(stopMode), .stopWake(stopWake),
		.stopOpcode(stopOpcode), .watchdogKick(watchdogKick), .lvmTripPin(lvmTripPin),
		.usbResetPin(usbResetPin), .resetPinN(resetPinN), .ctrl(ctrl)
	);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic complete_run();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_range(input string what, input int lo, input int hi, input int got);
		cmp_count++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic bail(input string what);
		n_errors++;
		$display("Error %s expected answer seen timeout", what);
		complete_run();
	endtask

	task automatic do_reset();
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		apbReq <= '{paddr: addr, pwrite: wr, pwdata: wd};
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		// pready is read at the edge, before that edge updates it
		do begin
			@(posedge ref_clk);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 20);
		if (apbRsp.pready !== 1'b1) bail("pready");
		rdv = apbRsp.prdata;
		err = apbRsp.pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0000_0000);
		chk(what, exp, rdv);
		chk("pslverr", 32'h0000_0000, {31'h0, err});
	endtask

	// pulses are one cycle wide, so every edge is looked at
	task automatic t_watchdog(input int period);
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge ref_clk);
				#1;
				n++;
			end while (ctrl.watchdogResetReq !== 1'b1 && n < period + 50);
			if (ctrl.watchdogResetReq !== 1'b1) bail("watchdog pulse");
		end
		chk_range("watchdog period", period - 1, period + 2, n);
		// a kick halfway must push the next expiry a full period out
		repeat (period / 2) @(posedge ref_clk);
		watchdogKick <= 1'b1;
		@(posedge ref_clk);
		watchdogKick <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (ctrl.watchdogResetReq !== 1'b1 && n < period + 50);
		if (ctrl.watchdogResetReq !== 1'b1) bail("watchdog kick");
		chk_range("watchdog kick", period, period + 1, n);
		$display("watchdog test done");
	endtask

	task automatic t_stop(input logic pinLow, input int delay, input logic osc, input logic rc,
		input logic lvm);
		int n;
		@(posedge ref_clk);
		stopMode <= 1'b1;
		resetPinN <= ~pinLow;
		@(posedge ref_clk);
		stopMode <= 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		chk("cpuClockRun stop", 32'h0000_0000, ctrl.cpuClockRun);
		chk("oscRunEnable", osc, ctrl.oscRunEnable);
		chk("rcClockEnable", rc, ctrl.rcClockEnable);
		chk("lvmActive stop", lvm, ctrl.lvmActive);
		@(posedge ref_clk);
		stopWake <= 1'b1;
		@(posedge ref_clk);
		stopWake <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (ctrl.cpuClockRun !== 1'b1 && n < 5000);
		if (ctrl.cpuClockRun !== 1'b1) bail("recovery");
		chk_range("recovery", delay - 1, delay + 3, n);
		chk("oscRunEnable run", 32'h0000_0001, ctrl.oscRunEnable);
		@(posedge ref_clk);
		resetPinN <= 1'b1;
		$display("stop test done");
	endtask

	task automatic t_pins(input logic lvm, input logic usb, input logic [2:0] exp);
		@(posedge ref_clk);
		lvmTripPin <= lvm;
		usbResetPin <= usb;
		repeat (5) @(posedge ref_clk);
		#1;
		chk("lvmResetReq", exp[2], ctrl.lvmResetReq);
		chk("usbChipResetReq", exp[1], ctrl.usbChipResetReq);
		chk("usbIrqReq", exp[0], ctrl.usbIrqReq);
		@(posedge ref_clk);
		lvmTripPin <= 1'b0;
		usbResetPin <= 1'b0;
		repeat (4) @(posedge ref_clk);
		$display("pin test done");
	endtask

	task automatic t_opcode(input logic exp);
		@(posedge ref_clk);
		stopOpcode <= 1'b1;
		@(posedge ref_clk);
		stopOpcode <= 1'b0;
		// the request stands for the single cycle after the opcode
		#1;
		chk("illegalOpcodeReq", exp, ctrl.illegalOpcodeReq);
		@(posedge ref_clk);
		#1;
		chk("illegalOpcodeReq end", 32'h0000_0000, ctrl.illegalOpcodeReq);
		$display("opcode test done");
	endtask

	task automatic t_levels(input logic [3:0] exp);
		// levels follow a register write one edge later
		@(posedge ref_clk);
		#1;
		chk("watchdogEnable", exp[3], ctrl.watchdogEnable);
		chk("lvmPowerEnable", exp[2], ctrl.lvmPowerEnable);
		chk("stopLegal", exp[1], ctrl.stopLegal);
		chk("usbRegulatorEnable", exp[0], ctrl.usbRegulatorEnable);
		$display("level test done");
	endtask

	task automatic t_write_once(input logic [7:0] a);
		apb(1'b1, sys_option_pkg::OPT_A_ADDR, {24'h1234_56, a});
		apb(1'b1, sys_option_pkg::OPT_A_ADDR, {24'h0000_00, ~a});
		rd_chk("option a", sys_option_pkg::OPT_A_ADDR, {24'h0, a});
		apb(1'b1, sys_option_pkg::OPT_B_ADDR, 32'h0000_00F3);
		rd_chk("option b", sys_option_pkg::OPT_B_ADDR, 32'h0000_00F3);
		apb(1'b1, sys_option_pkg::OPT_B_ADDR, 32'h0000_000C);
		rd_chk("option b", sys_option_pkg::OPT_B_ADDR, 32'h0000_000C);
		$display("write once test done");
	endtask

	task automatic t_cleared();
		rd_chk("option a reset", sys_option_pkg::OPT_A_ADDR, 32'h0000_0000);
		rd_chk("option b reset", sys_option_pkg::OPT_B_ADDR, 32'h0000_0000);
		apb(1'b0, 8'h78, 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, {31'h0, err});
		chk("unmapped data", 32'h0000_0000, rdv);
		$display("reset value test done");
	endtask

	// a stop request while the enable is low must leave no trace
	task automatic t_freeze();
		@(posedge ref_clk);
		ce <= 1'b0;
		stopMode <= 1'b1;
		@(posedge ref_clk);
		stopMode <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		chk("cpuClockRun frozen", 32'h0000_0001, ctrl.cpuClockRun);
		@(posedge ref_clk);
		ce <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		chk("cpuClockRun thawed", 32'h0000_0001, ctrl.cpuClockRun);
		$display("freeze test done");
	endtask

	initial begin
		n_errors = 0;
		cmp_count = 0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		apbReq = '0;
		stopMode = 1'b0;
		stopWake = 1'b0;
		stopOpcode = 1'b0;
		lvmTripPin = 1'b0;
		usbResetPin = 1'b0;
		resetPinN = 1'b1;
		ce = 1'b1;
		watchdogKick = 1'b0;
		do_reset();
		t_cleared();
		t_levels(4'b1101);
		t_write_once(8'h86);
		t_levels(4'b1111);
		t_opcode(1'b0);
		t_freeze();
		t_watchdog(sys_option_pkg::WD_SHORT_CYCLES);
		t_stop(1'b0, sys_option_pkg::REC_SHORT_CYCLES, 1'b1, 1'b1, 1'b0);
		apb(1'b1, sys_option_pkg::OPT_B_ADDR, 32'h0000_0001);
		t_stop(1'b1, sys_option_pkg::REC_LONG_CYCLES, 1'b0, 1'b0, 1'b0);
		t_pins(1'b0, 1'b1, 3'b001);
		apb(1'b1, sys_option_pkg::OPT_B_ADDR, 32'h0000_0002);
		t_levels(4'b1110);
		t_pins(1'b0, 1'b1, 3'b010);
		do_reset();
		t_cleared();
		t_write_once(8'h31);
		t_levels(4'b0001);
		t_opcode(1'b1);
		t_pins(1'b1, 1'b0, 3'b000);
		do_reset();
		t_pins(1'b1, 1'b0, 3'b100);
		t_watchdog(WD_LONG);
		t_stop(1'b0, sys_option_pkg::REC_LONG_CYCLES, 1'b0, 1'b0, 1'b0);
		apb(1'b1, sys_option_pkg::OPT_A_ADDR, 32'h0000_0060);
		t_stop(1'b0, sys_option_pkg::REC_LONG_CYCLES, 1'b0, 1'b0, 1'b1);
		t_pins(1'b1, 1'b0, 3'b000);
		complete_run();
	end
endmodule // tb
